// ### logic/cvt_pkg.sv
// Constants for the character-cell video timing generator
package cvt_pkg;
  localparam int unsigned CLK_FREQ_HZ    = 12528000;
  localparam int unsigned CHAR_FREQ_HZ   = 1566000;
  localparam int unsigned DOTS_PER_CHAR  = CLK_FREQ_HZ / CHAR_FREQ_HZ;
  localparam int unsigned CHAR_PERIOD_NS = 639;
  localparam logic [2:0] DOT_LAST     = 3'h7;
  localparam logic [2:0] PH1_START    = 3'h0;
  localparam logic [2:0] PH1_END      = 3'h2;
  localparam logic [2:0] PH2_START    = 3'h4;
  localparam logic [2:0] PH2_END      = 3'h6;
  localparam logic [2:0] HALF_CHAR    = 3'h4;
  localparam logic [6:0] CHAR_LAST    = 7'h63;
  localparam logic [6:0] DGATE_SET    = 7'h0f;
  localparam logic [6:0] DGATE_CLR    = 7'h5f;
  localparam logic [6:0] HORIZ_BLANKING_SET   = 7'h61;
  localparam logic [6:0] HORIZ_BLANKING_CLR   = 7'h0f;
  localparam logic [6:0] HORIZ_DRIVE_OUT_CLR   = 7'h1f;
  localparam logic [6:0] CSYNC_DELAY  = 7'h08;
  localparam logic [6:0] ROW_WIDTH    = 7'h50;
  localparam logic [3:0] SCAN_FIRST   = 4'h1;
  localparam logic [3:0] SCAN_NINTH   = 4'h9;
  localparam logic [3:0] SCAN_LAST    = 4'h9;
  localparam logic [4:0] LINE_CLEAR   = 5'h1d;
  localparam logic [4:0] VBLANK_SET   = 5'h1c;
  localparam logic [4:0] VBLANK_CLR   = 5'h03;
  localparam logic [4:0] VERT_DRIVE_OUT_CLR   = 5'h01;
  localparam logic [4:0] SECT_LINE_A  = 5'h0b;
  localparam logic [4:0] SECT_LINE_B  = 5'h13;
endpackage : cvt_pkg

// ### logic/cvt_phase_if.sv
// Character phase bundle shared between the divider and the top
`timescale 1ns/1ps
`default_nettype none
interface cvt_phase_if;
  logic       char_time_clk_n;
  logic [1:0] char_phase_clocks_n;
  logic       char_end;
  logic       half_char;
  modport src (output char_time_clk_n, char_phase_clocks_n, char_end,
               half_char);
  modport snk (input char_time_clk_n, char_phase_clocks_n, char_end,
               half_char);
endinterface : cvt_phase_if
`default_nettype wire

// ### logic/cvt_char_div.sv
// Divide-by-eight character timing and two-phase clocks
`timescale 1ns/1ps
`default_nettype none
module cvt_char_div
  import cvt_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  cvt_phase_if.src  ph
);
  typedef struct packed {
    logic [2:0] dot;
    logic       tclk_n;
    logic [1:0] ph_n;
  } cvt_div_st_t;

  cvt_div_st_t st;
  cvt_div_st_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.dot = (st.dot == DOT_LAST) ? 3'h0 : st.dot + 3'h1;
    next_st.tclk_n = (next_st.dot >= HALF_CHAR);
    // Phases never overlap: gap of one dot between them
    next_st.ph_n[0] = !(next_st.dot >= PH1_START &&
                        next_st.dot <= PH1_END);
    next_st.ph_n[1] = !(next_st.dot >= PH2_START &&
                        next_st.dot <= PH2_END);
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      st <= '{dot: 3'h0, tclk_n: 1'b1, ph_n: 2'h3};
    else
      st <= next_st;
  end

  assign ph.char_time_clk_n     = st.tclk_n;
  assign ph.char_phase_clocks_n = st.ph_n;
  assign ph.char_end            = (st.dot == DOT_LAST);
  assign ph.half_char           = (st.dot < HALF_CHAR);
endmodule : cvt_char_div
`default_nettype wire

// ### logic/cvt_timing_gen.sv
// Video timing generator top: horizontal, vertical and memory strobes
// What this block does
// - Runs entirely from one 12.528 MHz master clock.
// - Makes a 1.566 MHz character clock, master divided by eight.
// - Makes two non-overlapping phase clocks per character position.
// - Data window on at count 15, off at 95: 80 characters.
// - Horizontal blank on at count 97, off at count 15.
// - Horizontal drive on with blank, off at count 31.
// - Combined sync merges vertical drive and 8-character delayed drive.
// - Half-character pulse at data line 29 clears line counter.
// - Vertical blank from scan 1 line 28 to scan 9 line 3.
// - Vertical drive on with line clear pulse, off at line 1.
// - Decoded output active during ninth scan line of each row.
// - Section counter advances at scan 1 of lines 11 and 19.
// - Compare enable suppresses position compare during pause and sync.
// - Memory clock disable is the inverse of compare enable.
// - Memory clocks are inverted phases, gated off by clock disable.
// - Scroll enable is data window ANDed with a sync flip-flop.
// - End-of-row strobe after memories advance 80 positions.
// - Address match needs both position and line matches true.
`timescale 1ns/1ps
`default_nettype none
module cvt_timing_gen
  import cvt_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       mem_pause_i,
  input  wire logic       char_match_raw_i,
  input  wire logic       line_match_i,
  output logic            char_time_clk_n_o,
  output logic [1:0]      char_phase_clocks_n_o,
  output logic [1:0]      mem_phase_clocks_o,
  output logic            visible_data_window_o,
  output logic            horiz_blanking_o,
  output logic            horiz_drive_out_o,
  output logic            combined_sync_n_o,
  output logic            line_count_clear_pulse_o,
  output logic            vert_blanking_o,
  output logic            vert_drive_out_o,
  output logic            ninth_scanline_decode_o,
  output logic            first_scanline_o,
  output logic            last_scanline_o,
  output logic [1:0]      mem_section_select_o,
  output logic            compare_enable_o,
  output logic            char_position_match_o,
  output logic            mem_clock_disable_o,
  output logic            scroll_enable_o,
  output logic            mem_end_of_row_n_o,
  output logic            cursor_address_match_o,
  output logic [6:0]      char_count_o,
  output logic [3:0]      scan_count_o,
  output logic [4:0]      line_count_o
);
  typedef struct packed {
    logic [6:0] chr;
    logic [3:0] scan;
    logic [4:0] line;
    logic [1:0] sect;
    logic       dgate;
    logic       horiz_blanking;
    logic       horiz_drive_out;
    logic       horiz_drive_out_late;
    logic       vblank;
    logic       vert_drive_out;
    logic       clr_pulse;
    logic       clr_pend;
    logic       sync_ff;
    logic [6:0] shift_cnt;
    logic       eor;
    logic [1:0] mclk;
    logic       pause_s1;
    logic       pause_s2;
    logic       chm_s1;
    logic       chm_s2;
    logic       lnm_s1;
    logic       lnm_s2;
    logic       chmatch;
    logic       addmatch;
  } cvt_st_t;

  cvt_st_t st;
  cvt_st_t next_st;

  cvt_phase_if ph ();

  cvt_char_div u_div
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ph         (ph.src)
  );

  function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
    hit = (a == b);
  endfunction : hit

  logic cmp_en;
  logic vsync_win;

  // Sync intervals: vertical blank, vertical drive or line-counter clear in progress
  always_comb
  begin
    vsync_win = st.vblank || st.clr_pulse || st.vert_drive_out;
    cmp_en    = !(st.pause_s2 || vsync_win);
  end

  always_comb
  begin
    next_st = st;
    next_st.pause_s1 = mem_pause_i;
    next_st.pause_s2 = st.pause_s1;
    next_st.chm_s1   = char_match_raw_i;
    next_st.chm_s2   = st.chm_s1;
    next_st.lnm_s1   = line_match_i;
    next_st.lnm_s2   = st.lnm_s1;
    next_st.clr_pulse = 1'b0;
    next_st.mclk = ~ph.char_phase_clocks_n & {2{cmp_en}};
    next_st.chmatch  = st.chm_s2 && cmp_en;
    next_st.addmatch = st.chm_s2 && cmp_en && st.lnm_s2;
    // Clear pulse spans four dots, dot 1 through dot 4 of the character
    if (st.clr_pend)
    begin
      if (ph.half_char)
      begin
        next_st.clr_pulse = 1'b1;
        next_st.line      = 5'h00;
        next_st.vert_drive_out    = 1'b1;
        next_st.sync_ff   = 1'b1;
      end
      else
        next_st.clr_pend = 1'b0;
    end
    if (ph.char_end)
    begin
      next_st.chr = (st.chr == CHAR_LAST) ? 7'h00 : st.chr + 7'h01;
      if (hit(next_st.chr, DGATE_SET))
        next_st.dgate = 1'b1;
      if (hit(next_st.chr, DGATE_CLR))
        next_st.dgate = 1'b0;
      if (hit(next_st.chr, HORIZ_BLANKING_SET))
      begin
        next_st.horiz_blanking = 1'b1;
        next_st.horiz_drive_out = 1'b1;
      end
      if (hit(next_st.chr, HORIZ_BLANKING_CLR))
        next_st.horiz_blanking = 1'b0;
      if (hit(next_st.chr, HORIZ_DRIVE_OUT_CLR))
        next_st.horiz_drive_out = 1'b0;
      // Delayed copy of horizontal drive, 8 characters late
      if (hit(next_st.chr, HORIZ_BLANKING_SET + CSYNC_DELAY - 7'h64))
        next_st.horiz_drive_out_late = 1'b1;
      if (hit(next_st.chr, HORIZ_DRIVE_OUT_CLR + CSYNC_DELAY))
        next_st.horiz_drive_out_late = 1'b0;
      if (st.dgate)
        next_st.shift_cnt = st.shift_cnt + 7'h01;
      next_st.eor = (st.dgate && st.shift_cnt == ROW_WIDTH - 7'h01);
      if (hit(next_st.chr, DGATE_SET))
      begin
        next_st.shift_cnt = 7'h00;
        next_st.eor       = 1'b0;
      end
      if (st.chr == CHAR_LAST)
      begin
        next_st.scan = (st.scan == SCAN_LAST) ? SCAN_FIRST
                                              : st.scan + 4'h1;
        if (st.scan == SCAN_LAST)
        begin
          next_st.line = st.line + 5'h01;
          if (next_st.line == LINE_CLEAR)
            next_st.clr_pend = 1'b1;
          if (next_st.line == VERT_DRIVE_OUT_CLR)
            next_st.vert_drive_out = 1'b0;
        end
        if (next_st.scan == SCAN_FIRST && next_st.line == VBLANK_SET)
          next_st.vblank = 1'b1;
        if (next_st.scan == SCAN_NINTH && next_st.line == VBLANK_CLR)
        begin
          next_st.vblank  = 1'b0;
          next_st.sync_ff = 1'b0;
        end
        if (next_st.scan == SCAN_FIRST &&
            (next_st.line == SECT_LINE_A || next_st.line == SECT_LINE_B))
          next_st.sect = st.sect + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      // Count 0 lies inside horizontal blank and drive
      st <= '{scan: SCAN_FIRST, horiz_blanking: 1'b1, horiz_drive_out: 1'b1,
              default: '0};
    else
      st <= next_st;
  end

  assign char_time_clk_n_o        = ph.char_time_clk_n;
  assign char_phase_clocks_n_o    = ph.char_phase_clocks_n;
  assign mem_phase_clocks_o       = st.mclk;
  assign visible_data_window_o    = st.dgate;
  assign horiz_blanking_o         = st.horiz_blanking;
  assign horiz_drive_out_o        = st.horiz_drive_out;
  assign combined_sync_n_o        = !(st.vert_drive_out || st.horiz_drive_out_late);
  assign line_count_clear_pulse_o = st.clr_pulse;
  assign vert_blanking_o          = st.vblank;
  assign vert_drive_out_o         = st.vert_drive_out;
  assign ninth_scanline_decode_o  = (st.scan == SCAN_NINTH);
  assign first_scanline_o         = (st.scan == SCAN_FIRST);
  assign last_scanline_o          = (st.scan == SCAN_NINTH);
  assign mem_section_select_o     = st.sect;
  assign compare_enable_o         = cmp_en;
  assign char_position_match_o    = st.chmatch;
  assign mem_clock_disable_o      = !cmp_en;
  assign scroll_enable_o          = st.dgate && st.sync_ff;
  assign mem_end_of_row_n_o       = !st.eor;
  assign cursor_address_match_o   = st.addmatch;
  assign char_count_o             = st.chr;
  assign scan_count_o             = st.scan;
  assign line_count_o             = st.line;
endmodule : cvt_timing_gen
`default_nettype wire

// ### sim/cvt_timing_chk.sv
// Port checker for the video timing generator
`timescale 1ns/1ps
`default_nettype none
module cvt_timing_chk
  import cvt_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       char_match_raw_i,
  input wire logic       line_match_i,
  input wire logic [1:0] char_phase_clocks_n_o,
  input wire logic       visible_data_window_o,
  input wire logic       horiz_blanking_o,
  input wire logic       horiz_drive_out_o,
  input wire logic       ninth_scanline_decode_o,
  input wire logic       compare_enable_o,
  input wire logic       mem_clock_disable_o,
  input wire logic       char_position_match_o,
  input wire logic       cursor_address_match_o,
  input wire logic [6:0] char_count_o,
  input wire logic [3:0] scan_count_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  dgate_window_a: assert property (visible_data_window_o ==
    (char_count_o >= DGATE_SET && char_count_o < DGATE_CLR))
    else $error("data window misplaced");
  horiz_blanking_window_a: assert property (horiz_blanking_o ==
    (char_count_o >= HORIZ_BLANKING_SET || char_count_o < HORIZ_BLANKING_CLR))
    else $error("horizontal blank misplaced");
  horiz_drive_out_window_a: assert property (horiz_drive_out_o ==
    (char_count_o >= HORIZ_BLANKING_SET || char_count_o < HORIZ_DRIVE_OUT_CLR))
    else $error("horizontal drive misplaced");
  phase_overlap_a: assert property (char_phase_clocks_n_o != 2'h0)
    else $error("phase clocks overlap");
  char_wrap_a: assert property ($changed(char_count_o) |->
    char_count_o == (($past(char_count_o) == CHAR_LAST) ? 7'h00
    : $past(char_count_o) + 7'h01)) else $error("char count step wrong");
  char_hold_a: assert property ($changed(char_count_o) |=>
    $stable(char_count_o) [*7]) else $error("char time not 8 clocks");
  ninth_scan_a: assert property (ninth_scanline_decode_o ==
    (scan_count_o == SCAN_NINTH)) else $error("ninth scan decode wrong");
  clk_disable_a: assert property (mem_clock_disable_o != compare_enable_o)
    else $error("clock disable not inverse");
  match_gate_a: assert property (!compare_enable_o [*4] |->
    !char_position_match_o) else $error("match not suppressed");
  addr_both_a: assert property ($rose(cursor_address_match_o) |->
    $past(char_match_raw_i, 3) && $past(line_match_i, 3))
    else $error("address match without both matches");
endmodule : cvt_timing_chk
bind cvt_timing_gen cvt_timing_chk u_chk (.core_clk_i, .rst_i,
  .char_match_raw_i, .line_match_i, .char_phase_clocks_n_o,
  .visible_data_window_o, .horiz_blanking_o, .horiz_drive_out_o,
  .ninth_scanline_decode_o, .compare_enable_o, .mem_clock_disable_o,
  .char_position_match_o, .cursor_address_match_o, .char_count_o,
  .scan_count_o);
`default_nettype wire

// ### sim/cvt_cursor_model.sv
// Cursor position model feeding the raw match inputs
`timescale 1ns/1ps
`default_nettype none
module cvt_cursor_model
  import cvt_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       enable_i,
  input  wire logic [6:0] col_i,
  input  wire logic [4:0] row_i,
  input  wire logic [6:0] char_count_i,
  input  wire logic [4:0] line_count_i,
  output var logic        char_match_o,
  output var logic        line_match_o
);
  initial
  begin
    char_match_o = 1'b0;
    line_match_o = 1'b0;
  end
  always @(posedge core_clk_i)
  begin
    char_match_o <= #1 enable_i && char_count_i == col_i;
    line_match_o <= #1 enable_i && line_count_i == row_i;
  end
endmodule : cvt_cursor_model
`default_nettype wire

// ### sim/crt_video_timing_generator_tb_top.sv
// Self-checking bench for the video timing generator
`timescale 1ns/1ps
`default_nettype none
module crt_video_timing_generator_tb_top;
  import cvt_pkg::*;
  logic core_clk_i = 1'b0, rst_i = 1'b1, mem_pause_i = 1'b0, en = 1'b0;
  logic char_match_raw_i, line_match_i, char_time_clk_n_o, horiz_blanking_o;
  logic visible_data_window_o, horiz_drive_out_o, combined_sync_n_o;
  logic line_count_clear_pulse_o, vert_blanking_o, vert_drive_out_o;
  logic ninth_scanline_decode_o, first_scanline_o, last_scanline_o;
  logic compare_enable_o, char_position_match_o, mem_clock_disable_o;
  logic scroll_enable_o, mem_end_of_row_n_o, cursor_address_match_o;
  logic [1:0] char_phase_clocks_n_o, mem_phase_clocks_o, mem_section_select_o;
  logic [6:0] char_count_o, col = 7'h28;
  logic [4:0] line_count_o, row = 5'h00;
  logic [3:0] scan_count_o;
  int         failures, checked, e, c, d, pc, ac;
  logic [1:0] xp;
  cvt_timing_gen DUT (.*);
  cvt_cursor_model u_cursor (.core_clk_i, .enable_i(en), .col_i(col),
    .row_i(row), .char_count_i(char_count_o), .line_count_i(line_count_o),
    .char_match_o(char_match_raw_i), .line_match_o(line_match_i));
  always #5 core_clk_i = ~core_clk_i;
  // Clock edges since reset release
  always @(posedge core_clk_i) e <= rst_i ? 0 : e + 1;
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic watch(input int n);
    pc = 0;
    ac = 0;
    repeat (n)
    begin
      @(negedge core_clk_i);
      if (char_position_match_o === 1'b1) pc++;
      if (cursor_address_match_o === 1'b1) ac++;
    end
  endtask : watch
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic t_reset;
    chk("count", 0, char_count_o);
    chk("scan", 1, scan_count_o);
    chk("line", 0, line_count_o);
    chk("section", 0, mem_section_select_o);
    chk("phases", 3, char_phase_clocks_n_o);
    $display("Test reset done");
  endtask : t_reset
  task automatic t_horiz;
    repeat (800)
    begin
      @(negedge core_clk_i);
      d = e % 8;
      c = (e / 8) % 100;
      chk("count", c, char_count_o);
      chk("window", c >= 15 && c < 95, visible_data_window_o);
      chk("blank", c >= 97 || c < 15, horiz_blanking_o);
      chk("drive", c >= 97 || c < 31, horiz_drive_out_o);
      chk("sync", !(c >= 5 && c <= 38), combined_sync_n_o);
      chk("eor", c != 95, mem_end_of_row_n_o);
      chk("scroll", 0, scroll_enable_o);
      // Reset leaves the phase clocks idle for one more cycle
      chk("charclk", d >= 4 || e == 0, char_time_clk_n_o);
      xp = {d < 4 || d > 6, d > 2 || e == 0};
      chk("phases", xp, char_phase_clocks_n_o);
      d = (e + 7) % 8;
      xp = (e < 2) ? 2'h0 : {d >= 4 && d <= 6, d <= 2};
      chk("memclk", xp, mem_phase_clocks_o);
    end
    $display("Test horiz done");
  endtask : t_horiz
  task automatic t_scan;
    repeat (10)
    begin
      while (e % 800 != 400) @(negedge core_clk_i);
      c = 1 + (e / 800) % 9;
      chk("scan", c, scan_count_o);
      chk("ninth", c == 9, ninth_scanline_decode_o);
      chk("first", c == 1, first_scanline_o);
      chk("last", c == 9, last_scanline_o);
      @(negedge core_clk_i);
    end
    $display("Test scan done");
  endtask : t_scan
  task automatic t_match;
    @(posedge core_clk_i);
    #1 en = 1'b1;
    row = 5'(e / 7200);
    watch(1000);
    chk("addr_seen", 1, ac > 0);
    @(posedge core_clk_i);
    #1 row = row + 5'h01;
    watch(1000);
    chk("char_seen", 1, pc > 0);
    chk("addr_alone", 0, ac);
    @(posedge core_clk_i);
    #1 mem_pause_i = 1'b1;
    watch(10);
    chk("cmp_en", 0, compare_enable_o);
    chk("clk_dis", 1, mem_clock_disable_o);
    watch(1000);
    chk("memclk", 0, mem_phase_clocks_o);
    chk("paused", 0, pc);
    @(posedge core_clk_i);
    #1 mem_pause_i = 1'b0;
    $display("Test match done");
  endtask : t_match
  task automatic t_section;
    while (e < 79000) @(negedge core_clk_i);
    chk("sect_before", 0, mem_section_select_o);
    while (e < 79600) @(negedge core_clk_i);
    chk("line", 11, line_count_o);
    chk("sect_after", 1, mem_section_select_o);
    chk("vblank", 0, vert_blanking_o);
    chk("vert_drive_out", 0, vert_drive_out_o);
    chk("clr_pulse", 0, line_count_clear_pulse_o);
    $display("Test section done");
  endtask : t_section
  initial
  begin
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    t_reset();
    @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    t_horiz();
    t_scan();
    t_match();
    t_section();
    close_out();
  end
  initial
  begin
    #1000us;
    failures++;
    close_out();
  end
endmodule : crt_video_timing_generator_tb_top
`default_nettype wire
